// ### common/pcacr_pkg.sv
// Package of constants for the counter-array capture register block
package pcacr_pkg;

   // ------------------------------------------------------------------
   // Widths and counts
   // ------------------------------------------------------------------
   localparam int NUM_CH    = 6;                 // Capture/compare modules
   localparam int CNT_W     = 16;                // Counter and capture width
   localparam int BYTE_W    = 8;                 // Special-function register width

   // ------------------------------------------------------------------
   // Register offsets on the special-function-register bus
   // ------------------------------------------------------------------
   localparam logic [7:0] COUNTER_LOW_ADDR  = 8'hf9;
   localparam logic [7:0] COUNTER_HIGH_ADDR = 8'hfa;
   localparam logic [7:0] CAPCMP_LOW_ADDR  [NUM_CH] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hce};
   localparam logic [7:0] CAPCMP_HIGH_ADDR [NUM_CH] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hcf};

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   localparam logic [15:0] WORD_RESET  = 16'h0000;

   // ------------------------------------------------------------------
   // Cycle length codes for 8 to 11-bit pulse width modulation
   // ------------------------------------------------------------------
   localparam logic [1:0]  CYCLE_8_BITS  = 2'h0;
   localparam logic [1:0]  CYCLE_9_BITS  = 2'h1;
   localparam logic [1:0]  CYCLE_10_BITS = 2'h2;
   localparam logic [1:0]  CYCLE_11_BITS = 2'h3;
   localparam logic [15:0] MASK_8_BITS   = 16'h00ff;
   localparam logic [15:0] MASK_9_BITS   = 16'h01ff;
   localparam logic [15:0] MASK_10_BITS  = 16'h03ff;
   localparam logic [15:0] MASK_11_BITS  = 16'h07ff;
   localparam logic [15:0] MASK_16_BITS  = 16'hffff;

endpackage

// ### common/pcacr_chan_if.sv
// Interface between the register decoder and one capture/compare channel
`timescale 1ns/1ps
interface pcacr_chan_if;
   logic        ce;                  // Clock enable
   logic        wr_low;              // Write strobe, low byte address
   logic        wr_high;             // Write strobe, high byte address
   logic        auto_reload_select;  // Steers bytes to the reload value
   logic [7:0]  wdata;               // Write data
   logic [15:0] capcmp_value;        // Stored capture/compare value
   logic [15:0] reload_value;        // Stored auto-reload value
   logic        comparator_function_enable;

   modport regs (
      output ce,
      output wr_low,
      output wr_high,
      output auto_reload_select,
      output wdata,
      input  capcmp_value,
      input  reload_value,
      input  comparator_function_enable
   );

   modport chan (
      input  ce,
      input  wr_low,
      input  wr_high,
      input  auto_reload_select,
      input  wdata,
      output capcmp_value,
      output reload_value,
      output comparator_function_enable
   );
endinterface

// ### core/pcacr_chan.sv
// One capture/compare channel: value, auto-reload value and comparator enable
`timescale 1ns/1ps
module pcacr_chan (
   input  wire logic  sys_clk_i,
   input  wire logic  arst_n_i,
   pcacr_chan_if.chan ch
);

   typedef struct packed {
      logic [15:0] cap;
      logic [15:0] reload;
      logic        ecom;
   } pcacr_chan_state_t;

   pcacr_chan_state_t st;
   pcacr_chan_state_t next_st;

   // ------------------------------------------------------------------
   // Next state: byte writes and comparator enable side effects
   // ------------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (ch.ce) begin
         if (ch.wr_low) begin
            if (ch.auto_reload_select) begin
               next_st.reload[7:0] = ch.wdata;
            end else begin
               next_st.cap[7:0] = ch.wdata;
            end
            next_st.ecom = 1'b0;
         end
         if (ch.wr_high) begin
            if (ch.auto_reload_select) begin
               next_st.reload[15:8] = ch.wdata;
            end else begin
               next_st.cap[15:8] = ch.wdata;
            end
            next_st.ecom = 1'b1;
         end
      end
   end

   // State register, all bytes clear at reset
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '{cap: pcacr_pkg::WORD_RESET, reload: pcacr_pkg::WORD_RESET,
                 ecom: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign ch.capcmp_value               = st.cap;
   assign ch.reload_value               = st.reload;
   assign ch.comparator_function_enable = st.ecom;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_low_clears_enable;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (ch.ce && ch.wr_low && !ch.wr_high) |=> !ch.comparator_function_enable;
   endproperty
   a_low_clears_enable: assert property (p_low_clears_enable)
      else $error("Low byte write did not clear comparator enable");

   property p_high_sets_enable;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (ch.ce && ch.wr_high) |=> ch.comparator_function_enable;
   endproperty
   a_high_sets_enable: assert property (p_high_sets_enable)
      else $error("High byte write did not set comparator enable");

   property p_select_steers;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (ch.ce && ch.wr_low && ch.auto_reload_select) |=>
         (ch.reload_value[7:0] == $past(ch.wdata)) &&
         (ch.capcmp_value == $past(ch.capcmp_value));
   endproperty
   a_select_steers: assert property (p_select_steers)
      else $error("Reload select did not steer the low byte write");

   property p_capture_high_write;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (ch.ce && ch.wr_high && !ch.auto_reload_select) |=>
         (ch.capcmp_value[15:8] == $past(ch.wdata)) &&
         (ch.reload_value == $past(ch.reload_value));
   endproperty
   a_capture_high_write: assert property (p_capture_high_write)
      else $error("Capture high byte write not stored");

   property p_quiet_hold;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      !(ch.wr_low || ch.wr_high) |=> $stable(ch.comparator_function_enable) &&
         $stable(ch.capcmp_value) && $stable(ch.reload_value);
   endproperty
   a_quiet_hold: assert property (p_quiet_hold)
      else $error("Channel state changed without a write");

endmodule // pcacr_chan

// ### core/pcacr_regs.sv
// Counter and capture/compare byte registers of the programmable counter array
`timescale 1ns/1ps
// Overview of operation
// - A 16-bit counter is reached as separate low and high byte registers.
// - Counter byte writes are ignored while the watchdog enable is set.
// - High byte reads return a snapshot loaded when the low byte is read.
// - Six modules each hold a 16-bit value at their own byte pair.
// - Auto-reload select steers module byte accesses to the reload value.
// - Writing a module low byte clears its comparator enable.
// - Writing a module high byte sets its comparator enable.
// - Counter and module bytes reset to zero and are read/write.
// - Comparator enable gates comparison of counter against module value.
// - Cycle length codes select 8, 9, 10 or 11-bit cycles.
module pcacr_regs #(
   parameter int NUM_CH = pcacr_pkg::NUM_CH
) (
   input  wire logic               sys_clk_i,
   input  wire logic               arst_n_i,
   input  wire logic               ce_i,
   input  wire logic [7:0]         sfr_addr_i,
   input  wire logic               sfr_wr_i,
   input  wire logic               sfr_rd_i,
   input  wire logic [7:0]         sfr_wdata_i,
   output logic      [7:0]         sfr_rdata_o,
   input  wire logic               count_tick_i,
   input  wire logic               watchdog_enable_bit_i,
   input  wire logic               auto_reload_select_i,
   input  wire logic [1:0]         pwm_cycle_length_i,
   input  wire logic [NUM_CH-1:0]  pwm16_i,
   output logic      [15:0]        array_counter_value_o,
   output logic      [NUM_CH-1:0]  comparator_function_enable_o,
   output logic      [NUM_CH-1:0]  match_o,
   output logic                    cycle_end_o
);

   typedef struct packed {
      logic [15:0]       count;
      logic [7:0]        snapshot;
      logic [7:0]        rdata;
      logic [NUM_CH-1:0] match;
      logic              cycle_end;
   } pcacr_top_state_t;

   pcacr_top_state_t st;
   pcacr_top_state_t next_st;

   logic [15:0]       cap_arr    [NUM_CH];
   logic [15:0]       reload_arr [NUM_CH];
   logic [NUM_CH-1:0] ecom;
   logic [4:0]        wr_dec;

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------

   // Module address decode: {hit, high byte, index}
   function automatic logic [4:0] chan_decode(input logic [7:0] a);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < NUM_CH; i++) begin
         if (a == pcacr_pkg::CAPCMP_LOW_ADDR[i]) begin
            r = {1'b1, 1'b0, 3'(i)};
         end
         if (a == pcacr_pkg::CAPCMP_HIGH_ADDR[i]) begin
            r = {1'b1, 1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   // Counter bits that take part in an 8 to 11-bit cycle
   function automatic logic [15:0] cycle_mask(input logic [1:0] len);
      logic [15:0] m;
      case (len)
         pcacr_pkg::CYCLE_8_BITS:  m = pcacr_pkg::MASK_8_BITS;
         pcacr_pkg::CYCLE_9_BITS:  m = pcacr_pkg::MASK_9_BITS;
         pcacr_pkg::CYCLE_10_BITS: m = pcacr_pkg::MASK_10_BITS;
         pcacr_pkg::CYCLE_11_BITS: m = pcacr_pkg::MASK_11_BITS;
         default:                  m = pcacr_pkg::MASK_8_BITS;
      endcase
      return m;
   endfunction

   // ------------------------------------------------------------------
   // Capture/compare channels
   // ------------------------------------------------------------------
   assign wr_dec = chan_decode(sfr_addr_i);

   generate
      for (genvar n = 0; n < NUM_CH; n++) begin : gen_ch
         pcacr_chan_if u_if ();

         // Write strobes reach only the addressed channel
         assign u_if.ce                 = ce_i;
         assign u_if.wr_low             = sfr_wr_i && wr_dec[4] && !wr_dec[3] &&
                                          (wr_dec[2:0] == 3'(n));
         assign u_if.wr_high            = sfr_wr_i && wr_dec[4] && wr_dec[3] &&
                                          (wr_dec[2:0] == 3'(n));
         assign u_if.auto_reload_select = auto_reload_select_i;
         assign u_if.wdata              = sfr_wdata_i;
         assign cap_arr[n]              = u_if.capcmp_value;
         assign reload_arr[n]           = u_if.reload_value;
         assign ecom[n]                 = u_if.comparator_function_enable;

         pcacr_chan u_chan (
            .sys_clk_i (sys_clk_i),
            .arst_n_i  (arst_n_i),
            .ch        (u_if.chan)
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Next state: counter, snapshot, read data and comparators
   // ------------------------------------------------------------------
   always_comb begin
      logic [4:0]  rd_dec;
      logic [15:0] word;
      logic [15:0] mask;
      rd_dec  = chan_decode(sfr_addr_i);
      word    = pcacr_pkg::WORD_RESET;
      mask    = cycle_mask(pwm_cycle_length_i);
      next_st = st;
      if (ce_i) begin
         // Counter advances, a software write to a byte wins over the tick
         if (count_tick_i) begin
            next_st.count = st.count + 16'h0001;
         end
         if (sfr_wr_i && !watchdog_enable_bit_i) begin
            if (sfr_addr_i == pcacr_pkg::COUNTER_LOW_ADDR) begin
               next_st.count[7:0] = sfr_wdata_i;
            end
            if (sfr_addr_i == pcacr_pkg::COUNTER_HIGH_ADDR) begin
               next_st.count[15:8] = sfr_wdata_i;
            end
         end

         // Read data, registered; unmapped addresses read zero
         if (sfr_rd_i) begin
            next_st.rdata = pcacr_pkg::BYTE_RESET;
            if (sfr_addr_i == pcacr_pkg::COUNTER_LOW_ADDR) begin
               next_st.rdata    = st.count[7:0];
               next_st.snapshot = st.count[15:8];
            end else if (sfr_addr_i == pcacr_pkg::COUNTER_HIGH_ADDR) begin
               next_st.rdata = st.snapshot;
            end else if (rd_dec[4]) begin
               // Plain read, nothing else is touched
               word = auto_reload_select_i ? reload_arr[rd_dec[2:0]]
                                           : cap_arr[rd_dec[2:0]];
               next_st.rdata = rd_dec[3] ? word[15:8] : word[7:0];
            end
         end

         // Comparators run only while their enable is set
         for (int i = 0; i < NUM_CH; i++) begin
            if (pwm16_i[i]) begin
               next_st.match[i] = ecom[i] && (st.count == cap_arr[i]);
            end else begin
               next_st.match[i] = ecom[i] &&
                  ((st.count & mask) == (cap_arr[i] & mask));
            end
         end

         // End of an 8 to 11-bit cycle: all selected counter bits are ones
         next_st.cycle_end = count_tick_i && ((st.count & mask) == mask);
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '{count: pcacr_pkg::WORD_RESET, snapshot: pcacr_pkg::BYTE_RESET,
                 rdata: pcacr_pkg::BYTE_RESET, match: '0,
                 cycle_end: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs from flip-flops
   assign sfr_rdata_o                  = st.rdata;
   assign array_counter_value_o        = st.count;
   assign comparator_function_enable_o = ecom;
   assign match_o                      = st.match;
   assign cycle_end_o                  = st.cycle_end;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_counter_lock;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (ce_i && sfr_wr_i && watchdog_enable_bit_i && !count_tick_i) |=>
         (array_counter_value_o == $past(array_counter_value_o));
   endproperty
   a_counter_lock: assert property (p_counter_lock)
      else $error("Counter changed by a write while the watchdog is on");

   property p_counter_low_write;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (ce_i && sfr_wr_i && !watchdog_enable_bit_i &&
       sfr_addr_i == pcacr_pkg::COUNTER_LOW_ADDR) |=>
         (array_counter_value_o[7:0] == $past(sfr_wdata_i));
   endproperty
   a_counter_low_write: assert property (p_counter_low_write)
      else $error("Counter low byte write not stored");

   property p_snapshot_load;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (ce_i && sfr_rd_i && sfr_addr_i == pcacr_pkg::COUNTER_LOW_ADDR) ##1
      (ce_i && sfr_rd_i && sfr_addr_i == pcacr_pkg::COUNTER_HIGH_ADDR) |=>
         (sfr_rdata_o == $past(array_counter_value_o[15:8], 2));
   endproperty
   a_snapshot_load: assert property (p_snapshot_load)
      else $error("High byte read did not return the snapshot");

   property p_match_needs_enable;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      match_o[0] |-> $past(comparator_function_enable_o[0]);
   endproperty
   a_match_needs_enable: assert property (p_match_needs_enable)
      else $error("Match raised with comparator disabled");

   property p_cycle_end;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      cycle_end_o |-> (($past(array_counter_value_o) & cycle_mask($past(pwm_cycle_length_i)))
                       == cycle_mask($past(pwm_cycle_length_i)));
   endproperty
   a_cycle_end: assert property (p_cycle_end)
      else $error("Cycle end flagged on wrong counter value");

endmodule // pcacr_regs

// ### sim/tb_top.sv
// Self-checking testbench for the counter-array capture register block
`timescale 1ns/1ps
module tb_top;
   localparam int N = pcacr_pkg::NUM_CH;
   logic          sys_clk_i             = 1'b0;
   logic          arst_n_i              = 1'b0;
   logic          ce_i                  = 1'b1;
   logic [7:0]    sfr_addr_i            = 8'h00;
   logic          sfr_wr_i              = 1'b0;
   logic          sfr_rd_i              = 1'b0;
   logic [7:0]    sfr_wdata_i           = 8'h00;
   logic          count_tick_i          = 1'b0;
   logic          watchdog_enable_bit_i = 1'b0;
   logic          auto_reload_select_i  = 1'b0;
   logic [1:0]    pwm_cycle_length_i    = 2'h0;
   logic [N-1:0]  pwm16_i               = '0;
   logic [7:0]    sfr_rdata_o;
   logic [15:0]   array_counter_value_o;
   logic [N-1:0]  comparator_function_enable_o;
   logic [N-1:0]  match_o;
   logic          cycle_end_o;
   int            num_errors = 0;
   int            n_tests    = 0;
   int            seed       = 69941;
   logic [7:0]    exp_q[$];
   logic          rd_pend    = 1'b0;
   logic [N-1:0]  en_exp     = '0;
   logic [7:0]    cap_lo [N];
   logic [7:0]    cap_hi [N];

   // Clock generator
   always #2.5 sys_clk_i = ~sys_clk_i;

   pcacr_regs #(.NUM_CH(N)) uut (
      .sys_clk_i                    (sys_clk_i),
      .arst_n_i                     (arst_n_i),
      .ce_i                         (ce_i),
      .sfr_addr_i                   (sfr_addr_i),
      .sfr_wr_i                     (sfr_wr_i),
      .sfr_rd_i                     (sfr_rd_i),
      .sfr_wdata_i                  (sfr_wdata_i),
      .sfr_rdata_o                  (sfr_rdata_o),
      .count_tick_i                 (count_tick_i),
      .watchdog_enable_bit_i        (watchdog_enable_bit_i),
      .auto_reload_select_i         (auto_reload_select_i),
      .pwm_cycle_length_i           (pwm_cycle_length_i),
      .pwm16_i                      (pwm16_i),
      .array_counter_value_o        (array_counter_value_o),
      .comparator_function_enable_o (comparator_function_enable_o),
      .match_o                      (match_o),
      .cycle_end_o                  (cycle_end_o)
   );

   // --------------------------------------------------------------
   // Compare, bus and closing tasks
   // --------------------------------------------------------------
   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic check_rdata(input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected read data: expected %h, seen %h", exp, got);
      end
   endtask

   // One strobe cycle, released after the edge that takes it
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      sfr_addr_i  <= a;
      sfr_wr_i    <= w;
      sfr_rd_i    <= r;
      sfr_wdata_i <= d;
      @(posedge sys_clk_i);
      sfr_wr_i    <= 1'b0;
      sfr_rd_i    <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
      @(negedge sys_clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, 1'b1, a, 8'h00);
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Read monitor: data is settled by the falling edge after the taking edge
   always @(posedge sys_clk_i) rd_pend <= sfr_rd_i & ce_i & arst_n_i;
   always @(negedge sys_clk_i) begin
      if (rd_pend) begin
         if (exp_q.size() == 0) begin
            num_errors++;
            $display("unexpected read data: expected none, seen %h", sfr_rdata_o);
         end else begin
            check_rdata(exp_q.pop_front(), sfr_rdata_o);
         end
      end
   end

   // Watchdog against a hung run
   initial begin
      #25000;
      num_errors++;
      $display("unexpected run length: expected end of tests, seen timeout");
      complete_run();
   end

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin : main
      logic [15:0] m;
      repeat (5) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      // Reset values and an unmapped address
      for (int i = 0; i < N; i++) begin
         rd(pcacr_pkg::CAPCMP_LOW_ADDR[i], 8'h00);
         rd(pcacr_pkg::CAPCMP_HIGH_ADDR[i], 8'h00);
      end
      rd(pcacr_pkg::COUNTER_LOW_ADDR, 8'h00);
      rd(pcacr_pkg::COUNTER_HIGH_ADDR, 8'h00);
      rd(8'hc0, 8'h00);
      @(negedge sys_clk_i);
      check_val("enables", 16'h0000, 16'(comparator_function_enable_o));
      end_test("reset");
      // Counter bytes and the high byte snapshot
      wr(pcacr_pkg::COUNTER_LOW_ADDR, 8'h34);
      wr(pcacr_pkg::COUNTER_HIGH_ADDR, 8'h12);
      check_val("counter", 16'h1234, array_counter_value_o);
      rd(pcacr_pkg::COUNTER_LOW_ADDR, 8'h34);
      wr(pcacr_pkg::COUNTER_HIGH_ADDR, 8'h56);
      rd(pcacr_pkg::COUNTER_HIGH_ADDR, 8'h12);
      rd(pcacr_pkg::COUNTER_LOW_ADDR, 8'h34);
      rd(pcacr_pkg::COUNTER_HIGH_ADDR, 8'h56);
      end_test("counter");
      // Watchdog lock, then frozen clock enable
      watchdog_enable_bit_i <= 1'b1;
      wr(pcacr_pkg::COUNTER_LOW_ADDR, 8'haa);
      wr(pcacr_pkg::COUNTER_HIGH_ADDR, 8'hbb);
      check_val("counter", 16'h5634, array_counter_value_o);
      watchdog_enable_bit_i <= 1'b0;
      ce_i <= 1'b0;
      wr(pcacr_pkg::COUNTER_LOW_ADDR, 8'haa);
      check_val("counter", 16'h5634, array_counter_value_o);
      ce_i <= 1'b1;
      end_test("lock");
      // Module bytes and the enable side effects
      for (int i = 0; i < N; i++) begin
         cap_lo[i] = 8'($random(seed));
         cap_hi[i] = 8'($random(seed));
         wr(pcacr_pkg::CAPCMP_HIGH_ADDR[i], cap_hi[i]);
         en_exp[i] = 1'b1;
         check_val("enables", 16'(en_exp), 16'(comparator_function_enable_o));
         wr(pcacr_pkg::CAPCMP_LOW_ADDR[i], cap_lo[i]);
         en_exp[i] = 1'b0;
         check_val("enables", 16'(en_exp), 16'(comparator_function_enable_o));
         wr(pcacr_pkg::CAPCMP_HIGH_ADDR[i], cap_hi[i]);
         en_exp[i] = 1'b1;
         rd(pcacr_pkg::CAPCMP_LOW_ADDR[i], cap_lo[i]);
         rd(pcacr_pkg::CAPCMP_HIGH_ADDR[i], cap_hi[i]);
         @(negedge sys_clk_i);
         check_val("enables", 16'(en_exp), 16'(comparator_function_enable_o));
      end
      end_test("modules");
      // Reload values behind the same addresses
      auto_reload_select_i <= 1'b1;
      for (int i = 0; i < N; i++) begin
         wr(pcacr_pkg::CAPCMP_LOW_ADDR[i], 8'(i + 8'h40));
         wr(pcacr_pkg::CAPCMP_HIGH_ADDR[i], 8'(i + 8'h80));
         rd(pcacr_pkg::CAPCMP_LOW_ADDR[i], 8'(i + 8'h40));
         rd(pcacr_pkg::CAPCMP_HIGH_ADDR[i], 8'(i + 8'h80));
      end
      @(negedge sys_clk_i);
      auto_reload_select_i <= 1'b0;
      for (int i = 0; i < N; i++) begin
         rd(pcacr_pkg::CAPCMP_LOW_ADDR[i], cap_lo[i]);
         rd(pcacr_pkg::CAPCMP_HIGH_ADDR[i], cap_hi[i]);
      end
      end_test("reload");
      // Cycle end for every cycle length code
      for (int len = 0; len < 4; len++) begin
         m = (16'h0100 << len) - 16'h0001;
         pwm_cycle_length_i <= 2'(len);
         wr(pcacr_pkg::COUNTER_LOW_ADDR, 8'hfe);
         wr(pcacr_pkg::COUNTER_HIGH_ADDR, m[15:8]);
         // Two ticks: the first reaches the all-ones value, the second ends the cycle
         @(posedge sys_clk_i);
         count_tick_i <= 1'b1;
         @(posedge sys_clk_i);
         @(negedge sys_clk_i);
         check_val("counter", m, array_counter_value_o);
         check_val("cycle end", 16'h0000, 16'(cycle_end_o));
         @(posedge sys_clk_i);
         count_tick_i <= 1'b0;
         @(negedge sys_clk_i);
         check_val("counter", m + 16'h0001, array_counter_value_o);
         check_val("cycle end", 16'h0001, 16'(cycle_end_o));
         @(negedge sys_clk_i);
         check_val("cycle end", 16'h0000, 16'(cycle_end_o));
      end
      end_test("cycle length");
      // Match on module 0 only while its enable is set
      pwm16_i <= '1;
      wr(pcacr_pkg::COUNTER_LOW_ADDR, cap_lo[0]);
      wr(pcacr_pkg::COUNTER_HIGH_ADDR, cap_hi[0]);
      repeat (2) @(negedge sys_clk_i);
      check_val("match", 16'h0001, 16'(match_o[0]));
      wr(pcacr_pkg::CAPCMP_LOW_ADDR[0], cap_lo[0]);
      repeat (2) @(negedge sys_clk_i);
      check_val("match", 16'h0000, 16'(match_o[0]));
      end_test("match");
      repeat (3) @(negedge sys_clk_i);
      complete_run();
   end
endmodule // tb_top
